// File: rtl/mscp_pkg.sv
// Package with constants and types for the manual scan control panel.
package mscp_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int unsigned NUM_ROWS = 6;
	localparam int unsigned NUM_EXTRA = 3;
	localparam int unsigned NUM_PARAMS = 16;
	localparam int unsigned VAL_W = 24;
	localparam int unsigned PIDX_W = 4;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] REG_AUX_SEL = 4'h2;
	localparam logic [ADDR_W-1:0] REG_BASE_STEP = 4'h3;
	localparam logic [ADDR_W-1:0] REG_PARAM_IDX = 4'h4;
	localparam logic [ADDR_W-1:0] REG_PARAM_DATA = 4'h5;
	localparam logic [ADDR_W-1:0] REG_VERSION = 4'hF;

	// Field positions.
	localparam int unsigned CTRL_LOCKOUT_BIT = 0;
	localparam int unsigned AUX_A_LSB = 0;
	localparam int unsigned AUX_B_LSB = 8;

	// Reset values.
	localparam logic [PIDX_W-1:0] AUX_A_RESET = 4'hC;
	localparam logic [PIDX_W-1:0] AUX_B_RESET = 4'hD;
	localparam logic [VAL_W-1:0] BASE_STEP_RESET = 24'h002710;
	// Arbitrary value identifying this design revision.
	localparam logic [DATA_W-1:0] VERSION_VALUE = 32'h0000_0101;

	// Scaling divisors applied to the base step.
	localparam logic [VAL_W-1:0] DIV_TENTH = 24'h00000A;
	localparam logic [VAL_W-1:0] DIV_HUNDREDTH = 24'h000064;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned DEBOUNCE_MS = 5;
	localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned DOUBLE_MS = 500;
	localparam int unsigned DOUBLE_CYC = CLK_HZ / 1000 * DOUBLE_MS;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MSCP_SENS_UNITY = 3'b001,
		MSCP_SENS_TENTH = 3'b010,
		MSCP_SENS_HUNDREDTH = 3'b100
	} mscp_sens_type;

	typedef enum logic [2:0] {
		MSCP_TOG_IDLE = 3'b001,
		MSCP_TOG_ONE_DOWN = 3'b010,
		MSCP_TOG_DONE = 3'b100
	} mscp_tog_type;

	typedef struct packed {
		logic start;
		logic pause;
		logic stop;
	} mscp_cmd_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} mscp_bus_type;

endpackage : mscp_pkg

// File: rtl/mscp_param_mem.sv
// Small parameter memory with one registered read port and one write port.
`timescale 1ns/1ns
`default_nettype none

module mscp_param_mem (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [mscp_pkg::PIDX_W-1:0] waddr,
	input wire logic [mscp_pkg::VAL_W-1:0] wdata,
	// Read port
	input wire logic [mscp_pkg::PIDX_W-1:0] raddr,
	output logic [mscp_pkg::VAL_W-1:0] rdata
);

	logic [mscp_pkg::VAL_W-1:0] mem [mscp_pkg::NUM_PARAMS];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule : mscp_param_mem

`default_nettype wire

// File: rtl/mscp_panel.sv
// Top of the manual scan control panel logic.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - While the lock switch is locked, knob and button inputs change no parameter, but displays still show values.
// - Once unlocked, and with the software lockout clear, knob turns and sensitivity presses take effect again.
// - Six displays each show either their knob's value or one extra value stepped by the row button.
// - Each row lights the selection LED of the value currently shown.
// - Pressing or turning a knob switches its display straight back to that knob's value.
// - Each sensitivity press cycles the knob scale through unity, one tenth and one hundredth.
// - Sensitivity LEDs are dark at unity and light the tenth or hundredth LED when that is active.
// - One upward scan toggle issues a scan start.
// - One downward scan toggle issues a scan pause.
// - Two downward scan toggles in a row issue a scan stop.
// - The feedback toggle decodes the same way: up enables, one down pauses, two downs retract.
// - Emergency stop switches off scan and feedback at once, over every other input.
// - The two auxiliary knobs act on parameters chosen by software in a register.
module mscp_panel (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Panel inputs (asynchronous)
	input wire logic LOCK_SW,
	input wire logic [7:0] KNOB_STEP,
	input wire logic [7:0] KNOB_DIR,
	input wire logic [7:0] KNOB_PUSH,
	input wire logic [7:0] SENS_BTN,
	input wire logic [5:0] SEL_BTN,
	input wire logic SCAN_UP,
	input wire logic SCAN_DOWN,
	input wire logic FB_UP,
	input wire logic FB_DOWN,
	input wire logic ESTOP,
	// Register port
	input wire logic [mscp_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [mscp_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [mscp_pkg::DATA_W-1:0] REG_RDATA,
	// Displays and LEDs
	output logic [5:0] DISP_ROW,
	output logic [mscp_pkg::VAL_W-1:0] DISP_VALUE,
	output logic [23:0] SEL_LED,
	output logic [15:0] SENS_LED,
	// Commands to scan engine and feedback loop
	output logic SCAN_START,
	output logic SCAN_PAUSE,
	output logic SCAN_STOP,
	output logic FB_ENABLE,
	output logic FB_PAUSE,
	output logic FB_RETRACT
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int unsigned NIN = 44;
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] sync1_r;
	logic [NIN-1:0] sync2_r;
	logic [NIN-1:0] prev_r;
	logic [NIN-1:0] rise;

	assign raw_in = {LOCK_SW, ESTOP, FB_DOWN, FB_UP, SCAN_DOWN, SCAN_UP,
		SEL_BTN, SENS_BTN, KNOB_PUSH, KNOB_DIR, KNOB_STEP};

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	assign rise = sync2_r & ~prev_r;

	logic locked;
	logic [7:0] k_step;
	logic [7:0] k_dir;
	logic [7:0] k_push;
	logic [7:0] k_sens;
	logic [5:0] k_sel;
	assign k_step = rise[7:0];
	assign k_dir = sync2_r[15:8];
	assign k_push = rise[23:16];
	assign k_sens = rise[31:24];
	assign k_sel = rise[37:32];
	assign locked = sync2_r[43];

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	logic [mscp_pkg::PIDX_W-1:0] aux_a_r;
	logic [mscp_pkg::PIDX_W-1:0] aux_b_r;
	logic [mscp_pkg::VAL_W-1:0] base_step_r;
	logic lockout_r;
	logic [mscp_pkg::PIDX_W-1:0] pidx_r;
	logic sw_wr;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			aux_a_r <= mscp_pkg::AUX_A_RESET;
			aux_b_r <= mscp_pkg::AUX_B_RESET;
			base_step_r <= mscp_pkg::BASE_STEP_RESET;
			lockout_r <= 1'b0;
			pidx_r <= '0;
		end else if (REG_WR) begin
			if (REG_ADDR == mscp_pkg::REG_CTRL) begin
				lockout_r <= REG_WDATA[mscp_pkg::CTRL_LOCKOUT_BIT];
			end else if (REG_ADDR == mscp_pkg::REG_AUX_SEL) begin
				aux_a_r <= REG_WDATA[mscp_pkg::AUX_A_LSB +: mscp_pkg::PIDX_W];
				aux_b_r <= REG_WDATA[mscp_pkg::AUX_B_LSB +: mscp_pkg::PIDX_W];
			end else if (REG_ADDR == mscp_pkg::REG_BASE_STEP) begin
				base_step_r <= REG_WDATA[mscp_pkg::VAL_W-1:0];
			end else if (REG_ADDR == mscp_pkg::REG_PARAM_IDX) begin
				pidx_r <= REG_WDATA[mscp_pkg::PIDX_W-1:0];
			end
		end
	end

	assign sw_wr = REG_WR && (REG_ADDR == mscp_pkg::REG_PARAM_DATA);

	// Lock switch or software lockout both freeze knob and sensitivity edits; REG_PARAM_DATA writes still go through.
	logic edit_ok;
	assign edit_ok = !locked && !lockout_r;

	// ------------------------------------------------------------
	// Sensitivity per knob
	// ------------------------------------------------------------
	mscp_pkg::mscp_sens_type sens_r [8];

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 8; i++) begin
				sens_r[i] <= mscp_pkg::MSCP_SENS_UNITY;
			end
		end else if (edit_ok) begin
			for (int i = 0; i < 8; i++) begin
				if (k_sens[i]) begin
					case (sens_r[i])
						mscp_pkg::MSCP_SENS_UNITY: sens_r[i] <= mscp_pkg::MSCP_SENS_TENTH;
						mscp_pkg::MSCP_SENS_TENTH: sens_r[i] <= mscp_pkg::MSCP_SENS_HUNDREDTH;
						default: sens_r[i] <= mscp_pkg::MSCP_SENS_UNITY;
					endcase
				end
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			SENS_LED <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				SENS_LED[2*i] <= sens_r[i] == mscp_pkg::MSCP_SENS_TENTH;
				SENS_LED[2*i+1] <= sens_r[i] == mscp_pkg::MSCP_SENS_HUNDREDTH;
			end
		end
	end

	// ------------------------------------------------------------
	// Knob detent arbitration and step computation
	// ------------------------------------------------------------
	// Scaled steps are precomputed so one detent costs no divider.
	logic [mscp_pkg::VAL_W-1:0] step_tenth_r;
	logic [mscp_pkg::VAL_W-1:0] step_hund_r;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			step_tenth_r <= '0;
			step_hund_r <= '0;
		end else begin
			step_tenth_r <= base_step_r / mscp_pkg::DIV_TENTH;
			step_hund_r <= base_step_r / mscp_pkg::DIV_HUNDREDTH;
		end
	end

	// Knob i of 0..5 targets parameter i, knobs 6 and 7 follow the aux map.
	logic [2:0] act_knob;
	logic act_valid;
	logic [mscp_pkg::VAL_W-1:0] act_step;
	logic [mscp_pkg::PIDX_W-1:0] act_target;

	always_comb begin
		act_knob = 3'h0;
		act_valid = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (k_step[i]) begin
				act_knob = 3'(i);
				act_valid = 1'b1;
			end
		end
		case (sens_r[act_knob])
			mscp_pkg::MSCP_SENS_TENTH: act_step = step_tenth_r;
			mscp_pkg::MSCP_SENS_HUNDREDTH: act_step = step_hund_r;
			default: act_step = base_step_r;
		endcase
		if (act_knob == 3'h6) begin
			act_target = aux_a_r;
		end else if (act_knob == 3'h7) begin
			act_target = aux_b_r;
		end else begin
			act_target = {1'b0, act_knob};
		end
	end

	// Read-modify-write pipeline: stage 1 reads, stage 2 writes.
	logic upd_r;
	logic rd_req;
	logic upd_dir_r;
	logic [mscp_pkg::VAL_W-1:0] upd_step_r;
	logic [mscp_pkg::PIDX_W-1:0] upd_tgt_r;
	logic [mscp_pkg::VAL_W-1:0] mem_rdata;
	logic [mscp_pkg::PIDX_W-1:0] mem_raddr;
	logic mem_we;
	logic [mscp_pkg::PIDX_W-1:0] mem_waddr;
	logic [mscp_pkg::VAL_W-1:0] mem_wdata;
	assign rd_req = act_valid && edit_ok && !upd_r;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			upd_r <= 1'b0;
			upd_dir_r <= 1'b0;
			upd_step_r <= '0;
			upd_tgt_r <= '0;
		end else begin
			upd_r <= rd_req;
			upd_dir_r <= k_dir[act_knob];
			upd_step_r <= act_step;
			upd_tgt_r <= act_target;
		end
	end

	// A detent arriving while an update is in flight is dropped; detents
	// come milliseconds apart, so this trades nothing in practice.
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = upd_tgt_r;
		mem_wdata = mem_rdata;
		if (upd_r) begin
			mem_we = 1'b1;
			if (upd_dir_r) begin
				mem_wdata = mem_rdata + upd_step_r;
			end else begin
				mem_wdata = mem_rdata - upd_step_r;
			end
		end else if (sw_wr) begin
			mem_we = 1'b1;
			mem_waddr = pidx_r;
			mem_wdata = REG_WDATA[mscp_pkg::VAL_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Display selection per row
	// ------------------------------------------------------------
	logic [1:0] extra_r [6];
	logic [1:0] show_r [6];
	logic [2:0] scan_row_r;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 6; i++) begin
				extra_r[i] <= 2'h0;
				show_r[i] <= 2'h0;
			end
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (k_push[i] || k_step[i]) begin
					show_r[i] <= 2'h0;
				end else if (k_sel[i]) begin
					// Display choice is not a parameter, so it works while locked.
					if (show_r[i] == 2'h0) begin
						show_r[i] <= extra_r[i] + 2'h1;
					end else begin
						extra_r[i] <= (extra_r[i] == 2'(mscp_pkg::NUM_EXTRA - 1)) ?
							2'h0 : extra_r[i] + 2'h1;
						show_r[i] <= (extra_r[i] == 2'(mscp_pkg::NUM_EXTRA - 1)) ?
							2'h1 : extra_r[i] + 2'h2;
					end
				end
			end
		end
	end

	// Rows are multiplexed one per cycle; row i extra n reads entry i+6n,
	// which wraps in the 16-entry store, so high extras alias other entries.
	always_comb begin
		if (rd_req) begin
			mem_raddr = act_target;
		end else if (scan_row_r < 3'h6) begin
			mem_raddr = {1'b0, scan_row_r} + 4'(show_r[scan_row_r]) * 4'h6;
		end else begin
			mem_raddr = pidx_r;
		end
	end

	mscp_param_mem i_mscp_param_mem (
		.clk(MCLK),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	logic [2:0] row_d_r;
	logic row_ok_r;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			scan_row_r <= 3'h0;
			row_d_r <= 3'h0;
			row_ok_r <= 1'b0;
			DISP_ROW <= '0;
			DISP_VALUE <= '0;
			SEL_LED <= '0;
		end else begin
			scan_row_r <= (scan_row_r == 3'h6) ? 3'h0 : scan_row_r + 3'h1;
			row_d_r <= scan_row_r;
			row_ok_r <= !rd_req && scan_row_r < 3'h6;
			if (row_ok_r) begin
				DISP_ROW <= 6'h01 << row_d_r;
				DISP_VALUE <= mem_rdata;
			end
			for (int i = 0; i < 6; i++) begin
				SEL_LED[4*i +: 4] <= 4'h1 << show_r[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Scan and feedback toggle decoding
	// ------------------------------------------------------------
	mscp_pkg::mscp_cmd_type scan_cmd;
	mscp_pkg::mscp_cmd_type fb_cmd;
	logic estop;
	assign estop = sync2_r[42];

	mscp_pkg::mscp_tog_type scan_st_r;
	mscp_pkg::mscp_tog_type fb_st_r;
	logic [23:0] scan_tmr_r;
	logic [23:0] fb_tmr_r;

	// Toggle decoding is shared by both switches, so it lives in a function.
	function automatic mscp_pkg::mscp_cmd_type tog_cmd(
		input mscp_pkg::mscp_tog_type st, input logic up, input logic dn);
		tog_cmd = '0;
		if (up) begin
			tog_cmd.start = 1'b1;
		end else if (dn && st == mscp_pkg::MSCP_TOG_ONE_DOWN) begin
			tog_cmd.stop = 1'b1;
		end else if (dn) begin
			tog_cmd.pause = 1'b1;
		end
	endfunction : tog_cmd

	assign scan_cmd = tog_cmd(scan_st_r, rise[38], rise[39]);
	assign fb_cmd = tog_cmd(fb_st_r, rise[40], rise[41]);

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			scan_st_r <= mscp_pkg::MSCP_TOG_IDLE;
			scan_tmr_r <= '0;
		end else begin
			scan_tmr_r <= (scan_tmr_r != '0) ? scan_tmr_r - 24'h1 : 24'h0;
			case (scan_st_r)
				mscp_pkg::MSCP_TOG_IDLE: begin
					if (scan_cmd.pause) begin
						scan_st_r <= mscp_pkg::MSCP_TOG_ONE_DOWN;
						scan_tmr_r <= 24'(mscp_pkg::DOUBLE_CYC);
					end
				end
				mscp_pkg::MSCP_TOG_ONE_DOWN: begin
					if (scan_cmd.stop || scan_cmd.start || scan_tmr_r == '0) begin
						scan_st_r <= mscp_pkg::MSCP_TOG_IDLE;
					end
				end
				default: scan_st_r <= mscp_pkg::MSCP_TOG_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			fb_st_r <= mscp_pkg::MSCP_TOG_IDLE;
			fb_tmr_r <= '0;
		end else begin
			fb_tmr_r <= (fb_tmr_r != '0) ? fb_tmr_r - 24'h1 : 24'h0;
			case (fb_st_r)
				mscp_pkg::MSCP_TOG_IDLE: begin
					if (fb_cmd.pause) begin
						fb_st_r <= mscp_pkg::MSCP_TOG_ONE_DOWN;
						fb_tmr_r <= 24'(mscp_pkg::DOUBLE_CYC);
					end
				end
				mscp_pkg::MSCP_TOG_ONE_DOWN: begin
					if (fb_cmd.stop || fb_cmd.start || fb_tmr_r == '0) begin
						fb_st_r <= mscp_pkg::MSCP_TOG_IDLE;
					end
				end
				default: fb_st_r <= mscp_pkg::MSCP_TOG_IDLE;
			endcase
		end
	end

	// Emergency stop overrides everything, including the lock.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			SCAN_START <= 1'b0;
			SCAN_PAUSE <= 1'b0;
			SCAN_STOP <= 1'b0;
			FB_ENABLE <= 1'b0;
			FB_PAUSE <= 1'b0;
			FB_RETRACT <= 1'b0;
		end else if (estop) begin
			SCAN_START <= 1'b0;
			SCAN_PAUSE <= 1'b0;
			SCAN_STOP <= 1'b1;
			FB_ENABLE <= 1'b0;
			FB_PAUSE <= 1'b0;
			FB_RETRACT <= 1'b1;
		end else begin
			SCAN_START <= scan_cmd.start;
			SCAN_PAUSE <= scan_cmd.pause;
			SCAN_STOP <= scan_cmd.stop;
			if (fb_cmd.start) begin
				FB_ENABLE <= 1'b1;
			end else if (fb_cmd.stop) begin
				FB_ENABLE <= 1'b0;
			end
			FB_PAUSE <= fb_cmd.pause;
			FB_RETRACT <= fb_cmd.stop;
		end
	end

	// ------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			if (REG_ADDR == mscp_pkg::REG_CTRL) begin
				REG_RDATA <= {31'h0, lockout_r};
			end else if (REG_ADDR == mscp_pkg::REG_STATUS) begin
				REG_RDATA <= {26'h0, FB_ENABLE, estop, !edit_ok, locked,
					fb_st_r == mscp_pkg::MSCP_TOG_ONE_DOWN,
					scan_st_r == mscp_pkg::MSCP_TOG_ONE_DOWN};
			end else if (REG_ADDR == mscp_pkg::REG_AUX_SEL) begin
				REG_RDATA <= {20'h0, aux_b_r, 4'h0, aux_a_r};
			end else if (REG_ADDR == mscp_pkg::REG_BASE_STEP) begin
				REG_RDATA <= {8'h0, base_step_r};
			end else if (REG_ADDR == mscp_pkg::REG_PARAM_IDX) begin
				REG_RDATA <= {28'h0, pidx_r};
			end else if (REG_ADDR == mscp_pkg::REG_VERSION) begin
				REG_RDATA <= mscp_pkg::VERSION_VALUE;
			end else begin
				REG_RDATA <= '0;
			end
		end else begin
			REG_RDATA <= '0;
		end
	end

endmodule : mscp_panel

`default_nettype wire

// File: verification/mscp_panel_sva.sv
// Port assertions for the manual scan control panel.
`timescale 1ns/1ns
`default_nettype none

module mscp_panel_sva (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Panel inputs
	input wire logic LOCK_SW,
	input wire logic SCAN_UP,
	input wire logic FB_UP,
	input wire logic ESTOP,
	// Register port
	input wire logic REG_RD,
	input wire logic [mscp_pkg::DATA_W-1:0] REG_RDATA,
	// Outputs
	input wire logic [5:0] DISP_ROW,
	input wire logic [23:0] SEL_LED,
	input wire logic [15:0] SENS_LED,
	input wire logic SCAN_START,
	input wire logic SCAN_PAUSE,
	input wire logic SCAN_STOP,
	input wire logic FB_ENABLE,
	input wire logic FB_RETRACT
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	// A scan start or a rising feedback enable must trace back to a recent up pin actuation.
	logic [3:0] up_age_r;
	logic [3:0] fb_age_r;
	logic sel_ok;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			up_age_r <= 4'hF;
		end else if (SCAN_UP) begin
			up_age_r <= 4'h0;
		end else if (up_age_r != 4'hF) begin
			up_age_r <= up_age_r + 4'h1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			fb_age_r <= 4'hF;
		end else if (FB_UP) begin
			fb_age_r <= 4'h0;
		end else if (fb_age_r != 4'hF) begin
			fb_age_r <= fb_age_r + 4'h1;
		end
	end

	always_comb begin
		sel_ok = 1'b1;
		for (int r = 0; r < 6; r++) begin
			if (!$onehot0(SEL_LED[4*r +: 4])) begin
				sel_ok = 1'b0;
			end
		end
	end

	property p_rd_idle;
		!REG_RD |=> REG_RDATA == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_sens_code;
		(SENS_LED & (SENS_LED >> 1) & 16'h5555) == 16'h0;
	endproperty
	a_sens_code: assert property (p_sens_code)
		else $error("two scale LEDs lit");
	property p_sel_onehot;
		sel_ok;
	endproperty
	a_sel_onehot: assert property (p_sel_onehot)
		else $error("selection LEDs not one-hot");
	property p_disp_row;
		$onehot0(DISP_ROW);
	endproperty
	a_disp_row: assert property (p_disp_row)
		else $error("display rows overlap");
	property p_start_pulse;
		SCAN_START |=> !SCAN_START;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start longer than a pulse");
	property p_start_cause;
		SCAN_START |-> up_age_r < 4'hC;
	endproperty
	a_start_cause: assert property (p_start_cause)
		else $error("start without scan up");
	property p_fb_cause;
		$rose(FB_ENABLE) |-> fb_age_r < 4'hC;
	endproperty
	a_fb_cause: assert property (p_fb_cause)
		else $error("feedback on without up");
	property p_cmd_excl;
		$onehot0({SCAN_START, SCAN_PAUSE, SCAN_STOP});
	endproperty
	a_cmd_excl: assert property (p_cmd_excl)
		else $error("scan commands collide");
	property p_estop;
		ESTOP [*5] |-> SCAN_STOP && FB_RETRACT && !FB_ENABLE && !SCAN_START;
	endproperty
	a_estop: assert property (p_estop)
		else $error("emergency stop not obeyed");
	property p_lock;
		LOCK_SW [*4] |=> $stable(SENS_LED);
	endproperty
	a_lock: assert property (p_lock)
		else $error("scale changed while locked");
endmodule : mscp_panel_sva

bind mscp_panel mscp_panel_sva i_mscp_panel_sva (.MCLK(MCLK), .RST_N(RST_N),
	.LOCK_SW(LOCK_SW), .SCAN_UP(SCAN_UP), .FB_UP(FB_UP), .ESTOP(ESTOP),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DISP_ROW(DISP_ROW),
	.SEL_LED(SEL_LED), .SENS_LED(SENS_LED), .SCAN_START(SCAN_START),
	.SCAN_PAUSE(SCAN_PAUSE), .SCAN_STOP(SCAN_STOP), .FB_ENABLE(FB_ENABLE),
	.FB_RETRACT(FB_RETRACT));

`default_nettype wire

// File: verification/mscp_operator.sv
// Operator model: knobs, buttons and switches of the panel.
`timescale 1ns/1ns
`default_nettype none

module mscp_operator (
	// Clock
	input wire logic clk,
	// Knobs
	output logic [7:0] knob_step,
	output logic [7:0] knob_dir,
	output logic [7:0] knob_push,
	output logic [7:0] sens_btn,
	// Buttons and switches
	output logic [5:0] sel_btn,
	output logic scan_up,
	output logic scan_down,
	output logic fb_up,
	output logic fb_down,
	output logic lock_sw,
	output logic estop
);
	// Released contacts fall back to low, like the real pull-downs.
	logic [43:0] pins_r = '0;

	assign knob_step = pins_r[7:0];
	assign knob_push = pins_r[15:8];
	assign sens_btn = pins_r[23:16];
	assign sel_btn = pins_r[29:24];
	assign scan_up = pins_r[30];
	assign scan_down = pins_r[31];
	assign fb_up = pins_r[32];
	assign fb_down = pins_r[33];
	assign lock_sw = pins_r[34];
	assign estop = pins_r[35];
	assign knob_dir = pins_r[43:36];

	task automatic tap(input int b);
		@(posedge clk);
		pins_r[b] <= 1'b1;
		repeat (4) @(posedge clk);
		pins_r[b] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : tap

	task automatic lvl(input int b, input logic v);
		@(posedge clk);
		pins_r[b] <= v;
	endtask : lvl
endmodule : mscp_operator

`default_nettype wire

// File: verification/mscp_panel_bench.sv
// Self-checking bench for the manual scan control panel.
`timescale 1ns/1ns
`default_nettype none

module mscp_panel_bench;
	localparam int KS = 0;
	localparam int KP = 8;
	localparam int SB = 18;
	localparam int SL = 26;
	localparam int SU = 30;
	localparam int SD = 31;
	localparam int FU = 32;
	localparam int FD = 33;
	localparam int LK = 34;
	localparam int ES = 35;
	localparam int KD = 38;

	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic [mscp_pkg::ADDR_W-1:0] reg_addr = 4'h0;
	logic [mscp_pkg::DATA_W-1:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	wire [mscp_pkg::DATA_W-1:0] reg_rdata;
	wire [7:0] k_step, k_dir, k_push, s_btn;
	wire [5:0] sel_btn, disp_row;
	wire s_up, s_dn, f_up, f_dn, lock, estop;
	wire [23:0] disp_value, sel_led;
	wire [15:0] sens_led;
	wire s_start, s_pause, s_stop, f_en, f_pause, f_retract;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n_start = 0;
	int n_stop = 0;
	int n_pause = 0;

	initial begin
		forever #25 MCLK = ~MCLK;
	end

	mscp_operator i_mscp_operator (.clk(MCLK), .knob_step(k_step),
		.knob_dir(k_dir), .knob_push(k_push), .sens_btn(s_btn),
		.sel_btn(sel_btn), .scan_up(s_up), .scan_down(s_dn), .fb_up(f_up),
		.fb_down(f_dn), .lock_sw(lock), .estop(estop));

	mscp_panel i_mscp_panel (.MCLK(MCLK), .RST_N(RST_N), .LOCK_SW(lock),
		.KNOB_STEP(k_step), .KNOB_DIR(k_dir), .KNOB_PUSH(k_push),
		.SENS_BTN(s_btn), .SEL_BTN(sel_btn), .SCAN_UP(s_up),
		.SCAN_DOWN(s_dn), .FB_UP(f_up), .FB_DOWN(f_dn), .ESTOP(estop),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DISP_ROW(disp_row),
		.DISP_VALUE(disp_value), .SEL_LED(sel_led), .SENS_LED(sens_led),
		.SCAN_START(s_start), .SCAN_PAUSE(s_pause), .SCAN_STOP(s_stop),
		.FB_ENABLE(f_en), .FB_PAUSE(f_pause), .FB_RETRACT(f_retract));

	always @(posedge MCLK) begin
		cyc++;
		if (s_start === 1'b1) n_start++;
		if (s_stop === 1'b1) n_stop++;
		if (s_pause === 1'b1 || f_pause === 1'b1) n_pause++;
		if (cyc == 80000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge MCLK);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge MCLK);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge MCLK);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge MCLK);
		reg_rd <= 1'b0;
		#1;
		chk("read data", e, reg_rdata);
	endtask : rd_chk

	// The display is multiplexed, so wait for row two to be on show.
	task automatic disp_chk(input logic [23:0] e);
		int n;
		n = 0;
		repeat (8) @(posedge MCLK);
		#1;
		while (disp_row[2] !== 1'b1 && n < 4000) begin
			@(posedge MCLK);
			#1;
			n++;
		end
		chk("display value", {8'h0, e}, {8'h0, disp_value});
	endtask : disp_chk

	task automatic led_chk(input logic [1:0] s, input logic [3:0] l);
		repeat (8) @(posedge MCLK);
		#1;
		chk("scale leds", {30'h0, s}, {30'h0, sens_led[5:4]});
		chk("select leds", {28'h0, l}, {28'h0, sel_led[11:8]});
	endtask : led_chk

	initial begin
		repeat (8) @(posedge MCLK);
		RST_N <= 1'b1;
		rd_chk(4'h2, 32'h0000_0D0C);
		rd_chk(4'h3, 32'h0000_2710);
		rd_chk(4'hF, mscp_pkg::VERSION_VALUE);
		rd_chk(4'h9, 32'h0);
		wr(4'h2, 32'h0000_0305);
		rd_chk(4'h2, 32'h0000_0305);
		wr(4'h3, 32'h0000_0064);
		wr(4'h4, 32'h0000_0002);
		wr(4'h5, 32'h0000_1000);
		i_mscp_operator.tap(SB);
		led_chk(2'b01, 4'h1);
		i_mscp_operator.tap(SB);
		led_chk(2'b10, 4'h1);
		i_mscp_operator.tap(SB);
		led_chk(2'b00, 4'h1);
		i_mscp_operator.lvl(LK, 1'b1);
		i_mscp_operator.tap(SB);
		led_chk(2'b00, 4'h1);
		i_mscp_operator.lvl(LK, 1'b0);
		i_mscp_operator.tap(SB);
		led_chk(2'b01, 4'h1);
		i_mscp_operator.tap(SL);
		led_chk(2'b01, 4'h2);
		i_mscp_operator.tap(SL);
		led_chk(2'b01, 4'h4);
		i_mscp_operator.tap(KP + 2);
		led_chk(2'b01, 4'h1);
		disp_chk(24'h001000);
		i_mscp_operator.lvl(KD, 1'b1);
		i_mscp_operator.tap(KS + 2);
		disp_chk(24'h00100A);
		i_mscp_operator.lvl(KD, 1'b0);
		i_mscp_operator.tap(KS + 2);
		i_mscp_operator.tap(KS + 2);
		disp_chk(24'h000FF6);
		i_mscp_operator.lvl(LK, 1'b1);
		i_mscp_operator.tap(KS + 2);
		disp_chk(24'h000FF6);
		i_mscp_operator.lvl(LK, 1'b0);
		i_mscp_operator.tap(SB);
		i_mscp_operator.tap(SL);
		i_mscp_operator.lvl(KD, 1'b1);
		i_mscp_operator.tap(KS + 2);
		led_chk(2'b10, 4'h1);
		disp_chk(24'h000FF7);
		i_mscp_operator.tap(SB);
		i_mscp_operator.tap(KS + 2);
		disp_chk(24'h00105B);
		i_mscp_operator.tap(SU);
		repeat (8) @(posedge MCLK);
		chk("start pulses", 32'd1, n_start);
		i_mscp_operator.tap(SD);
		i_mscp_operator.tap(SD);
		repeat (8) @(posedge MCLK);
		chk("stop pulses", 32'd1, n_stop);
		chk("pause pulses", 32'd1, n_pause);
		i_mscp_operator.tap(FU);
		repeat (8) @(posedge MCLK);
		chk("feedback on", 32'd1, {31'h0, f_en});
		i_mscp_operator.tap(FD);
		i_mscp_operator.tap(FD);
		repeat (8) @(posedge MCLK);
		chk("feedback pauses", 32'd2, n_pause);
		chk("feedback off", 32'd0, {31'h0, f_en});
		i_mscp_operator.lvl(ES, 1'b1);
		repeat (8) @(posedge MCLK);
		chk("estop state", 32'd3, {29'h0, f_en, s_stop, f_retract});
		i_mscp_operator.lvl(ES, 1'b0);
		repeat (8) @(posedge MCLK);
		wrap_up();
	end
endmodule : mscp_panel_bench

`default_nettype wire
